// File: wsm_pkg.sv
// Constants for the write start and modulator control block.
// Assumes byte registers on a 32-bit Avalon-MM slave, byte address = index * 4.
// Functional notes
// RULE1: bit 7 sets laser flag, reads back
// RULE2: bit 6 sets data flag, reads back
// RULE3: delay enable adds wobble pulse offset delay
// RULE4: five-bit count delays flags by syncs
// RULE5: start offset delays flags on start; code delays only the laser flag, data flag moves once the sync count is done
// RULE6: stop offset delays flags on stop; code delays only the laser flag, data flag moves once the sync count is done
// RULE7: phase offset loaded by two selectable writes
// RULE8: phase offset is signed ten bits
// RULE9: phase offset added to sync phase error
// RULE10: frame and disc syncs steer start/stop
// RULE11: preset count sets frame start position
// RULE12: config bit 7 doubles recording clock
// RULE13: config bit 6 stretches zero symbols
// RULE14: enable-on-write lets laser follow flag
// RULE15: force bit turns laser on always; code lets panic, when enabled and asserted, keep the laser off
// RULE16: gate bit runs clock unconditionally; code lets alternate clock mode override the gate bit
// RULE17: panic input kills laser when enabled
// RULE18: three select bits choose output format
// RULE19: modulator adds sync, subcode, serialises
// RULE20: subcode supplied externally, bypass only
// RULE21: format codes zero, normal, I3, I11, calibration
// RULE22: alternate clock mode overrides gate bit
// RULE23: preset reserved bits ignored
package wsm_pkg;
  // ---------------------------------------------------------------
  // Register indexes (byte address is four times these)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_WCTRL = 8'h30;
  localparam logic [7:0] IDX_START = 8'h31;
  localparam logic [7:0] IDX_STOP = 8'h32;
  localparam logic [7:0] IDX_XOFF = 8'h33;
  localparam logic [7:0] IDX_PRESET = 8'h3C;
  localparam logic [7:0] IDX_MCFG = 8'h3D;
  localparam logic [7:0] IDX_MCFG2 = 8'h3E;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int WC_LASER = 7;
  localparam int WC_DATA = 6;
  localparam int WC_DELAY = 5;
  localparam int MC_DOUBLE = 7;
  localparam int MC_STRETCH = 6;
  localparam int MC_LWRITE = 5;
  localparam int MC_LFORCE = 4;
  localparam int MC_GATE = 3;
  localparam int MC_PANIC = 0;
  localparam int MC2_ALT_MODE = 2;
  localparam int MC2_ALT_ON = 1;
  localparam logic [1:0] XOFF_LO = 2'h0;
  localparam logic [1:0] XOFF_HI = 2'h1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ---------------------------------------------------------------
  // Output formats and frame layout
  // ---------------------------------------------------------------
  localparam logic [2:0] FMT_ZERO = 3'h0;
  localparam logic [2:0] FMT_NORMAL = 3'h1;
  localparam logic [2:0] FMT_I3 = 3'h2;
  localparam logic [2:0] FMT_I11 = 3'h3;
  localparam logic [2:0] FMT_CAL = 3'h5;
  localparam logic [3:0] RUN_I3 = 4'h3;
  localparam logic [3:0] RUN_I11 = 4'hB;
  localparam logic [3:0] RUN_CAL_FIRST = 4'h3;
  localparam logic [3:0] CAL_LAST_IDX = 4'h9;
  localparam logic [5:0] SYMS_PER_FRAME = 6'h22;
  localparam logic [4:0] SYNC_BITS_M1 = 5'h1A;
  localparam logic [4:0] SYM_BITS_M1 = 5'h10;
  // Encode control states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_PULSE = 3'b100
  } wsm_state_t;
endpackage

// File: wsm_write_ctrl.sv
// Write start control, phase offset and channel modulator, one clock domain.
// Assumes sync/panic pins are asynchronous; symbol sources run on MCLK.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
module wsm_write_ctrl #(
  parameter logic [7:0] RCLK_HALF = 8'h04,        // MCLK cycles per half recording clock
  parameter logic [23:0] SYNC_PATTERN = 24'h80_1002 // Frame sync channel bits
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic PREGROOVE_TIME_SYNC,
  input wire logic WOBBLE_POSITION_PULSE,
  input wire logic SUBCHANNEL_FRAME_SYNC,
  input wire logic PANIC,
  input wire logic [13:0] ENC_SYMBOL,
  input wire logic ENC_VALID,
  output logic ENC_ACK,
  input wire logic [13:0] SUB_SYMBOL,
  input wire logic SUB_VALID,
  output logic SUB_ACK,
  output logic DATA_OUT,
  output logic RECORDING_CLOCK_OUT,
  output logic LASER_ENABLE_OUT,
  output logic [15:0] PHASE_ERROR,
  output logic PHASE_VALID
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Register index match, used by write decode and read mux
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction
  // Sign-extend the ten-bit phase offset
  function automatic logic [15:0] sext10(input logic [9:0] v);
    sext10 = {{6{v[9]}}, v};
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_s1_q; // First stage, read only by second stage
  logic [3:0] pin_s2_q; // Stable copies
  logic [3:0] pin_d_q;  // Delayed for edge finding
  // Two flops against metastability; order pregroove, wobble, frame, panic
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_d_q <= 4'h0;
    end else begin
      pin_s1_q <= {PANIC, SUBCHANNEL_FRAME_SYNC, WOBBLE_POSITION_PULSE, PREGROOVE_TIME_SYNC};
      pin_s2_q <= pin_s1_q;
      pin_d_q <= pin_s2_q;
    end
  end
  logic pre_edge; // Pregroove time sync rising edge
  logic wob_edge; // Wobble position pulse rising edge
  logic frm_edge; // Subchannel frame sync rising edge
  logic panic_s;  // Synchronised panic level
  assign pre_edge = pin_s2_q[0] & ~pin_d_q[0];
  assign wob_edge = pin_s2_q[1] & ~pin_d_q[1];
  assign frm_edge = pin_s2_q[2] & ~pin_d_q[2];
  assign panic_s = pin_s2_q[3];

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  logic wait_q;     // Waitrequest, high unless answering
  logic [7:0] idx;  // Register index
  logic wr_en;      // Write takes effect this edge
  logic [7:0] wd;   // Low byte lane
  assign idx = AVS_ADDRESS[9:2];
  assign wd = AVS_WRITEDATA[7:0];
  assign wr_en = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];
  // One wait cycle per request; keeps read data a flop output
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wait_q <= 1'b1;
    end else if ((AVS_READ | AVS_WRITE) & wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end
  assign AVS_WAITREQUEST = wait_q;

  logic laser_flag_q; // Laser write flag
  logic data_flag_q;  // Data flow flag
  logic delay_en_q;   // Offset delay enable
  logic [4:0] count_q;
  logic [7:0] start_off_q;
  logic [7:0] stop_off_q;
  logic [9:0] xoff_q;
  logic [5:0] preset_q;
  logic [7:0] mcfg_q;
  logic [2:0] mcfg2_q;
  logic [31:0] rdata_q;
  // Read data latched as waitrequest drops; write-only registers read zero
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ & wait_q) begin
      if (hit(idx, wsm_pkg::IDX_WCTRL)) begin
        rdata_q <= {24'h00_0000, laser_flag_q, data_flag_q, delay_en_q, count_q}; // RULE1 RULE2
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end
  assign AVS_READDATA = rdata_q;

  // Configuration writes
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      delay_en_q <= 1'b0;
      count_q <= 5'h00;
      start_off_q <= wsm_pkg::RST_BYTE;
      stop_off_q <= wsm_pkg::RST_BYTE;
      xoff_q <= 10'h000;
      preset_q <= 6'h00;
      mcfg_q <= wsm_pkg::RST_BYTE;
      mcfg2_q <= 3'h0;
    end else if (wr_en) begin
      if (hit(idx, wsm_pkg::IDX_WCTRL)) begin
        delay_en_q <= wd[wsm_pkg::WC_DELAY];
        count_q <= wd[4:0];
      end
      if (hit(idx, wsm_pkg::IDX_START)) begin
        start_off_q <= wd;
      end
      if (hit(idx, wsm_pkg::IDX_STOP)) begin
        stop_off_q <= wd;
      end
      // Either half may come first
      if (hit(idx, wsm_pkg::IDX_XOFF) && wd[7:6] == wsm_pkg::XOFF_LO) begin
        xoff_q[5:0] <= wd[5:0]; // RULE7
      end
      if (hit(idx, wsm_pkg::IDX_XOFF) && wd[7:6] == wsm_pkg::XOFF_HI) begin
        xoff_q[9:6] <= wd[3:0]; // RULE7
      end
      if (hit(idx, wsm_pkg::IDX_PRESET)) begin
        preset_q <= wd[5:0]; // RULE23
      end
      if (hit(idx, wsm_pkg::IDX_MCFG)) begin
        mcfg_q <= wd;
      end
      if (hit(idx, wsm_pkg::IDX_MCFG2)) begin
        mcfg2_q <= wd[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Encode control
  // ---------------------------------------------------------------
  wsm_pkg::wsm_state_t state_q;
  logic tgt_laser_q;   // Requested laser flag
  logic tgt_data_q;    // Requested data flag
  logic starting_q;    // Laser turning on, use start offset
  logic [4:0] syncs_left_q;
  logic [7:0] pulses_left_q;
  logic armed_q;       // Pregroove sync seen, counting pulses
  logic wctrl_wr;
  assign wctrl_wr = wr_en & hit(idx, wsm_pkg::IDX_WCTRL);
  // A new write restarts the sequence with fresh targets
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_q <= wsm_pkg::ST_IDLE;
      laser_flag_q <= 1'b0;
      data_flag_q <= 1'b0;
      tgt_laser_q <= 1'b0;
      tgt_data_q <= 1'b0;
      starting_q <= 1'b0;
      syncs_left_q <= 5'h00;
      pulses_left_q <= 8'h00;
      armed_q <= 1'b0;
    end else if (wctrl_wr) begin
      tgt_laser_q <= wd[wsm_pkg::WC_LASER];
      tgt_data_q <= wd[wsm_pkg::WC_DATA];
      starting_q <= wd[wsm_pkg::WC_LASER] & ~laser_flag_q;
      syncs_left_q <= wd[4:0]; // RULE4
      state_q <= wsm_pkg::ST_SYNC;
    end else begin
      case (state_q)
        wsm_pkg::ST_IDLE: begin
          armed_q <= 1'b0;
        end
        wsm_pkg::ST_SYNC: begin
          if (syncs_left_q == 5'h00) begin
            data_flag_q <= tgt_data_q; // RULE2
            if (delay_en_q && tgt_laser_q != laser_flag_q) begin
              // Offset counted in wobble pulses after a pregroove sync
              pulses_left_q <= starting_q ? start_off_q : stop_off_q; // RULE3 RULE5 RULE6
              armed_q <= 1'b0;
              state_q <= wsm_pkg::ST_PULSE;
            end else begin
              laser_flag_q <= tgt_laser_q; // RULE1
              state_q <= wsm_pkg::ST_IDLE;
            end
          end else if (pre_edge) begin
            syncs_left_q <= syncs_left_q - 5'h01; // RULE4 RULE10
          end
        end
        wsm_pkg::ST_PULSE: begin
          if (!armed_q) begin
            armed_q <= pre_edge; // RULE10
          end else if (pulses_left_q == 8'h00) begin
            laser_flag_q <= tgt_laser_q; // RULE3
            state_q <= wsm_pkg::ST_IDLE;
          end else if (wob_edge) begin
            pulses_left_q <= pulses_left_q - 8'h01; // RULE5 RULE6
          end
        end
        default: begin
          state_q <= wsm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Phase error between pregroove sync and subchannel frame sync
  // ---------------------------------------------------------------
  logic [15:0] phase_cnt_q; // Cycles since last pregroove sync, saturating
  logic [15:0] perr_q;
  logic pvalid_q;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      phase_cnt_q <= 16'h0000;
      perr_q <= 16'h0000;
      pvalid_q <= 1'b0;
    end else begin
      if (pre_edge) begin
        phase_cnt_q <= 16'h0000;
      end else if (phase_cnt_q != 16'hFFFF) begin
        phase_cnt_q <= phase_cnt_q + 16'h0001;
      end
      pvalid_q <= frm_edge;
      if (frm_edge) begin
        perr_q <= phase_cnt_q + sext10(xoff_q); // RULE8 RULE9
      end
    end
  end
  assign PHASE_ERROR = perr_q;
  assign PHASE_VALID = pvalid_q;

  // ---------------------------------------------------------------
  // Recording clock divider and gate
  // ---------------------------------------------------------------
  logic [7:0] div_q;
  logic [7:0] half;   // Half period in MCLK cycles
  logic clk_ph_q;     // Free running recording clock phase
  logic bit_stb;      // One channel bit per recording clock period
  logic gate;
  logic rclk_q;
  assign half = mcfg_q[wsm_pkg::MC_DOUBLE] ? (RCLK_HALF >> 1) : RCLK_HALF; // RULE12
  assign bit_stb = (div_q >= half - 8'h01) & ~clk_ph_q;
  // Mode bits from the second config register take priority
  assign gate = mcfg2_q[wsm_pkg::MC2_ALT_MODE] ? mcfg2_q[wsm_pkg::MC2_ALT_ON] // RULE22
              : (mcfg_q[wsm_pkg::MC_GATE] | data_flag_q); // RULE16
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      div_q <= 8'h00;
      clk_ph_q <= 1'b0;
    end else if (div_q >= half - 8'h01) begin
      div_q <= 8'h00;
      clk_ph_q <= ~clk_ph_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  // Gated copy only; the divider keeps running so the bit timing never jumps
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= clk_ph_q & gate; // RULE16
    end
  end
  assign RECORDING_CLOCK_OUT = rclk_q;

  // ---------------------------------------------------------------
  // Serialiser: sync, subcode symbol, 32 data symbols per frame
  // ---------------------------------------------------------------
  logic mod_run_q;
  logic [5:0] sym_idx_q;
  logic [4:0] bits_left_q;
  logic [26:0] shift_q;
  logic nrzi_q;     // Output level, toggles on channel one
  logic last_q;     // Last emitted channel bit
  logic ins_q;      // Extra zero already inserted
  logic enc_ack_q;
  logic sub_ack_q;
  logic load;
  logic [26:0] word;
  logic cur_bit;
  logic stall;
  logic [13:0] enc_sym;
  logic [13:0] sub_sym;
  assign load = (bits_left_q == 5'h00);
  // Missing symbols go out as zero rather than stall the disc
  assign enc_sym = ENC_VALID ? ENC_SYMBOL : 14'h0000;
  assign sub_sym = SUB_VALID ? SUB_SYMBOL : 14'h0000; // RULE20
  // Next word, left aligned, three zero merging bits after each symbol
  always_comb begin
    if (!load) begin
      word = shift_q;
    end else if (sym_idx_q == 6'h00) begin
      word = {SYNC_PATTERN, 3'h0}; // RULE19
    end else if (sym_idx_q == 6'h01) begin
      word = {sub_sym, 3'h0, 10'h000}; // RULE19
    end else begin
      word = {enc_sym, 3'h0, 10'h000};
    end
  end
  assign cur_bit = word[26];
  assign stall = mcfg_q[wsm_pkg::MC_STRETCH] & cur_bit & ~last_q & ~ins_q; // RULE13
  always_ff @(posedge MCLK) begin
    if (SRST || !data_flag_q) begin
      mod_run_q <= 1'b0;
      sym_idx_q <= 6'h00;
      bits_left_q <= 5'h00;
      shift_q <= 27'h000_0000;
      nrzi_q <= 1'b0;
      last_q <= 1'b0;
      ins_q <= 1'b0;
      enc_ack_q <= 1'b0;
      sub_ack_q <= 1'b0;
    end else if (!mod_run_q) begin
      if (frm_edge) begin
        // Start at the preset symbol on a frame boundary
        mod_run_q <= 1'b1; // RULE10
        sym_idx_q <= (preset_q < wsm_pkg::SYMS_PER_FRAME) ? preset_q : 6'h00; // RULE11
        bits_left_q <= 5'h00;
      end
    end else begin
      enc_ack_q <= bit_stb & ~stall & load & (sym_idx_q > 6'h01) & ENC_VALID;
      sub_ack_q <= bit_stb & ~stall & load & (sym_idx_q == 6'h01) & SUB_VALID; // RULE20
      if (bit_stb && stall) begin
        ins_q <= 1'b1; // RULE13
        last_q <= 1'b0;
      end else if (bit_stb) begin
        shift_q <= {word[25:0], 1'b0};
        if (load) begin
          bits_left_q <= (sym_idx_q == 6'h00) ? wsm_pkg::SYNC_BITS_M1 : wsm_pkg::SYM_BITS_M1;
          sym_idx_q <= (sym_idx_q == wsm_pkg::SYMS_PER_FRAME - 6'h01) ? 6'h00 : sym_idx_q + 6'h01;
        end else begin
          bits_left_q <= bits_left_q - 5'h01;
        end
        nrzi_q <= nrzi_q ^ cur_bit; // RULE19
        last_q <= cur_bit;
        ins_q <= 1'b0;
      end
    end
  end
  assign ENC_ACK = enc_ack_q;
  assign SUB_ACK = sub_ack_q;

  // ---------------------------------------------------------------
  // Test patterns and output format
  // ---------------------------------------------------------------
  logic [2:0] fmt;
  logic [3:0] run_cnt_q;
  logic [3:0] run_idx_q;
  logic pat_q;
  logic [3:0] run_len;
  logic dout_q;
  assign fmt = {mcfg2_q[0], mcfg_q[2:1]}; // RULE18
  // Calibration runs 3,3,4,4,...,7,7
  always_comb begin
    case (fmt)
      wsm_pkg::FMT_I3: run_len = wsm_pkg::RUN_I3;
      wsm_pkg::FMT_I11: run_len = wsm_pkg::RUN_I11;
      default: run_len = wsm_pkg::RUN_CAL_FIRST + {1'b0, run_idx_q[3:1]}; // RULE21
    endcase
  end
  always_ff @(posedge MCLK) begin
    if (SRST || fmt == wsm_pkg::FMT_ZERO || fmt == wsm_pkg::FMT_NORMAL) begin
      run_cnt_q <= 4'h0;
      run_idx_q <= 4'h0;
      pat_q <= 1'b0;
    end else if (bit_stb) begin
      if (run_cnt_q >= run_len - 4'h1) begin
        run_cnt_q <= 4'h0;
        pat_q <= ~pat_q;
        run_idx_q <= (run_idx_q == wsm_pkg::CAL_LAST_IDX) ? 4'h0 : run_idx_q + 4'h1;
      end else begin
        run_cnt_q <= run_cnt_q + 4'h1;
      end
    end
  end
  // Reserved codes hold the output low like code zero
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      dout_q <= 1'b0;
    end else begin
      case (fmt)
        wsm_pkg::FMT_NORMAL: dout_q <= nrzi_q & mod_run_q; // RULE21
        wsm_pkg::FMT_I3, wsm_pkg::FMT_I11, wsm_pkg::FMT_CAL: dout_q <= pat_q; // RULE21
        default: dout_q <= 1'b0; // RULE21
      endcase
    end
  end
  assign DATA_OUT = dout_q;

  // ---------------------------------------------------------------
  // Laser enable
  // ---------------------------------------------------------------
  logic laser_q;
  // Panic wins over force, force over the write flag
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      laser_q <= 1'b0;
    end else if (mcfg_q[wsm_pkg::MC_PANIC] & panic_s) begin
      laser_q <= 1'b0; // RULE17
    end else if (mcfg_q[wsm_pkg::MC_LFORCE]) begin
      laser_q <= 1'b1; // RULE15
    end else begin
      laser_q <= mcfg_q[wsm_pkg::MC_LWRITE] & laser_flag_q; // RULE14
    end
  end
  assign LASER_ENABLE_OUT = laser_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  panic_kill_a: assert property (mcfg_q[0] && panic_s |=> !LASER_ENABLE_OUT) // RULE17
    else $error("laser on during panic");
  laser_force_a: assert property (mcfg_q[4] && !(mcfg_q[0] && panic_s) |=> LASER_ENABLE_OUT) // RULE15
    else $error("forced laser not on");
  laser_gate_a: assert property (!mcfg_q[5] && !mcfg_q[4] |=> !LASER_ENABLE_OUT) // RULE14
    else $error("laser on while not enabled");
  flag_readback_a: assert property (AVS_READ && wait_q && hit(idx, 8'h30) // RULE1
    |=> AVS_READDATA[7:6] == $past({laser_flag_q, data_flag_q}) && !AVS_WAITREQUEST)
    else $error("flag readback wrong");
  sync_hold_a: assert property (state_q == wsm_pkg::ST_SYNC && syncs_left_q != 5'h00 && !wctrl_wr // RULE4
    |=> $stable(data_flag_q) && $stable(laser_flag_q))
    else $error("flag changed before sync count");
  start_hold_a: assert property (state_q == wsm_pkg::ST_PULSE && starting_q && pulses_left_q != 8'h00 // RULE5
    |=> $stable(laser_flag_q))
    else $error("laser started before offset");
  stop_hold_a: assert property (state_q == wsm_pkg::ST_PULSE && !starting_q && pulses_left_q != 8'h00 // RULE6
    |=> $stable(laser_flag_q))
    else $error("laser stopped before offset");
  xoff_low_a: assert property (wr_en && hit(idx, 8'h33) && wd[7:6] == 2'h0 // RULE7
    |=> xoff_q[5:0] == $past(wd[5:0]) && $stable(xoff_q[9:6]))
    else $error("phase offset low half not loaded");
  phase_sum_a: assert property (frm_edge |=> PHASE_VALID && PHASE_ERROR == $past(phase_cnt_q + sext10(xoff_q))) // RULE9
    else $error("phase error sum wrong");
  alt_clk_off_a: assert property (mcfg2_q[2] && !mcfg2_q[1] |=> !RECORDING_CLOCK_OUT) // RULE22
    else $error("recording clock not forced off");
  fmt_zero_a: assert property (fmt == 3'h0 ##1 fmt == 3'h0 |=> !DATA_OUT) // RULE21
    else $error("output not held at zero");
  laser_on_c: cover property (!LASER_ENABLE_OUT ##1 LASER_ENABLE_OUT);
  pulse_wait_c: cover property (state_q == wsm_pkg::ST_PULSE && wob_edge);
  stretch_c: cover property (bit_stb && stall && mod_run_q);
  frame_start_c: cover property (!mod_run_q ##1 mod_run_q);
endmodule

// File: wsm_laser_model.sv
// Far-side model: laser driver and write strategy input stage.
// Assumes its clock is the system clock and the recording clock is sampled.
`timescale 1ns/1ns
module wsm_laser_model (
  input wire logic clk,
  input wire logic rec_clk,
  input wire logic data_in,
  input wire logic laser_en,
  output int rises,
  output int flips
);
  // ------------------------------------------------------------
  // Recording clock edge counter and write pulse capture
  // ------------------------------------------------------------
  logic rec_q = 1'b0; // Last sampled recording clock
  logic dat_q = 1'b0; // Last sampled data level
  initial rises = 0;
  initial flips = 0;
  // Count rises; data edges only burn marks while the laser is enabled
  always @(posedge clk) begin
    if (rec_clk && !rec_q) begin
      rises <= rises + 1;
    end
    if (laser_en && data_in != dat_q) begin
      flips <= flips + 1;
    end
    rec_q <= rec_clk;
    dat_q <= data_in;
  end
endmodule

// File: wsm_write_ctrl_test.sv
// Self-checking bench for the write start and modulator control block.
// Assumes the default recording clock divider and a 250 MHz system clock.
`timescale 1ns/1ns
module wsm_write_ctrl_test;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0; // System clock
  logic srst = 1'b1; // Reset held at start
  logic [9:0] adr = 10'h000; // Byte address
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic preg = 1'b0; // Sync and wobble pins, 80 ns pulse period
  logic wob = 1'b0;
  logic fsync = 1'b0;
  logic panic = 1'b0;
  logic [31:0] rdat;
  logic wreq, dout, rclk, laser, suback;
  logic subv = 1'b0; // Subcode symbol offered
  logic [15:0] perr;
  int rises, flips, acks = 0, errors = 0, total_checks = 0;
  // Subcode symbols taken by the modulator
  always @(posedge clk) begin
    if (suback) acks <= acks + 1;
  end
  always #2 clk = ~clk;
  wsm_write_ctrl DUT (.MCLK(clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .PREGROOVE_TIME_SYNC(preg), .WOBBLE_POSITION_PULSE(wob), .SUBCHANNEL_FRAME_SYNC(fsync),
    .PANIC(panic), .ENC_SYMBOL(14'h0000), .ENC_VALID(1'b0), .ENC_ACK(), .SUB_SYMBOL(14'h0000),
    .SUB_VALID(subv), .SUB_ACK(suback), .DATA_OUT(dout), .RECORDING_CLOCK_OUT(rclk),
    .LASER_ENABLE_OUT(laser), .PHASE_ERROR(perr), .PHASE_VALID());
  wsm_laser_model far (.clk(clk), .rec_clk(rclk), .data_in(dout), .laser_en(laser), .rises(rises),
    .flips(flips));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    if (n >= 40) begin
      errors++;
      complete_run();
    end
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrt(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
    wt(6);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q & mask, exp);
  endtask
  // Pulse the sync pin (0), the wobble pin (1) or the frame pin (2), then let it settle
  task automatic pls(input int k);
    for (int i = 0; i < 16; i++) begin
      if (k == 0) preg <= (i < 8);
      else if (k == 1) wob <= (i < 8);
      else fsync <= (i < 8);
      @(posedge clk);
    end
    wt(4);
  endtask
  // Recording clock rises over 100 system cycles
  task automatic span(output int d);
    int c0;
    c0 = rises;
    wt(100);
    d = rises - c0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    wrt(8'h30, 8'hC0);
    rdc(8'h30, 8'hC0, 8'hC0);
    rdc(8'h31, 8'hFF, 8'h00);
    rdc(8'h3F, 8'hFF, 8'h00);
    wrt(8'h30, 8'h00);
    rdc(8'h30, 8'hC0, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_count;
    wrt(8'h30, 8'hC2); // Two sync events before flags move
    pls(0);
    rdc(8'h30, 8'hC0, 8'h00);
    pls(0);
    rdc(8'h30, 8'hC0, 8'hC0);
    wrt(8'h30, 8'h00);
    $display("test sync count done");
  endtask
  task automatic t_offset;
    wrt(8'h31, 8'h03);
    wrt(8'h30, 8'hE0); // Data flag at once, laser after sync plus 3 pulses
    rdc(8'h30, 8'hC0, 8'h40);
    pls(0);
    pls(1);
    pls(1);
    rdc(8'h30, 8'hC0, 8'h40);
    pls(1);
    rdc(8'h30, 8'hC0, 8'hC0);
    wrt(8'h32, 8'h02);
    wrt(8'h30, 8'h20);
    rdc(8'h30, 8'hC0, 8'h80);
    pls(0);
    pls(1);
    rdc(8'h30, 8'hC0, 8'h80);
    pls(1);
    rdc(8'h30, 8'hC0, 8'h00);
    wrt(8'h30, 8'h00);
    $display("test offset delay done");
  endtask
  task automatic t_phase;
    wrt(8'h33, 8'h4F);
    wrt(8'h33, 8'h3E);
    pls(0);
    pls(2);
    // Frame pin 20 cycles after sync pin, first cycle counts zero, offset -2
    chk(perr, 16'h0011);
    $display("test phase offset done");
  endtask
  task automatic t_sub;
    wrt(8'h3C, 8'hC1); // Reserved bits set; start at the subcode slot
    wrt(8'h30, 8'h40);
    subv <= 1'b1;
    pls(2);
    chk(acks, 16'h0001);
    subv <= 1'b0;
    wrt(8'h30, 8'h00);
    $display("test subcode slot done");
  endtask
  task automatic t_laser;
    wrt(8'h3D, 8'h20);
    chk(laser, 1'b0);
    wrt(8'h30, 8'hC0);
    chk(laser, 1'b1);
    wrt(8'h3D, 8'h00);
    chk(laser, 1'b0);
    wrt(8'h30, 8'h00);
    wrt(8'h3D, 8'h11); // Forced on, panic input armed
    chk(laser, 1'b1);
    panic <= 1'b1;
    wt(6);
    chk(laser, 1'b0);
    panic <= 1'b0;
    wt(6);
    chk(laser, 1'b1);
    wrt(8'h3D, 8'h00);
    $display("test laser enable done");
  endtask
  task automatic t_clock;
    int d;
    span(d);
    chk(d, 16'h0000);
    wrt(8'h30, 8'h40);
    span(d);
    chk(d >= 11 && d <= 14, 1'b1);
    wrt(8'h30, 8'h00);
    wrt(8'h3D, 8'h88); // Gate forced, doubled rate
    span(d);
    chk(d >= 23 && d <= 27, 1'b1);
    wrt(8'h3D, 8'h9C); // Laser forced, I3 pattern at double rate
    d = flips;
    wt(100);
    chk((flips - d) inside {[8:9]}, 1'b1);
    wrt(8'h3E, 8'h04); // Alternate mode, clock off
    span(d);
    chk(d, 16'h0000);
    wrt(8'h3E, 8'h00);
    $display("test recording clock done");
  endtask
  initial begin
    wt(3);
    srst <= 1'b0;
    wt(1);
    t_regs();
    t_count();
    t_offset();
    t_phase();
    t_sub();
    t_laser();
    t_clock();
    complete_run();
  end
endmodule
